//--- src/rcr_pkg.sv
package rcr_pkg;

  // Register byte offsets on the APB slave
  localparam logic [7:0] OFS_CAUSE   = 8'h00;
  localparam logic [7:0] OFS_LVSEL   = 8'h04;
  localparam logic [7:0] OFS_LVCTL   = 8'h08;
  localparam logic [7:0] OFS_IRQ_STS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h10;

  // Cause register field positions
  localparam int CAUSE_BRN_BIT = 0;
  localparam int CAUSE_WDG_BIT = 1;
  localparam int CAUSE_BAD_BIT = 4;

  // Detect control field positions
  localparam int LVCTL_EN_BIT   = 7;
  localparam int LVCTL_MODE_BIT = 1;

  // Reset values
  localparam logic [7:0] LVSEL_RST   = 8'h0E;
  localparam logic [7:0] LVCTL_RST   = 8'h00;
  localparam logic [4:0] IRQ_MSK_RST = 5'h00;

  // Opcode that traps as illegal
  localparam logic [7:0] BAD_OPCODE = 8'hFF;

  // Oscillation stabilization wait
  localparam int         CLK_PERIOD_NS = 40;
  localparam int         OSC_WAIT_NS   = 2000;
  localparam logic [6:0] OSC_WAIT_CYC  =
    7'((OSC_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // One bit per reset source
  typedef struct packed {
    logic lvd;
    logic wdg;
    logic bad;
    logic power_on_clear;
    logic pin;
  } rst_src_t;

  // Cause flags kept across watchdog, bad-opcode and low-voltage resets
  typedef struct packed {
    logic bad;
    logic wdg;
    logic brn;
  } cause_t;

  typedef enum logic [1:0] {
    ST_RUN  = 2'b01,
    ST_WAIT = 2'b10
  } seq_state_t;

endpackage : rcr_pkg

//--- src/rise_sync.sv
`timescale 1ns/100ps
// Two-flop synchroniser with a one-cycle pulse on the rising synced level
module rise_sync (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Async level in, pulse out
  input  wire logic async_in,
  output logic      rise_pulse
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // Only sync_r reads meta_r
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign rise_pulse = sync_r & ~prev_r;

endmodule : rise_sync

//--- src/reset_cause_recorder.sv
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
module reset_cause_recorder
  import rcr_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Reset sources
  input  wire logic        rst_pin_n,
  input  wire logic        poc_active,
  input  wire logic        wdg_expire,
  input  wire logic        lvd_trip,
  // Instruction execute snoop
  input  wire logic        op_exec,
  input  wire logic [7:0]  op_code,
  // Option byte: undervoltage detector on by default
  input  wire logic        opt_lvd_default_on,
  // Reset sequencing
  output logic             sys_reset_req,
  output logic             pc_undefined,
  output logic             reset_ack,
  // Interrupt
  output logic             irq
);

  rst_src_t   src;
  cause_t     cause_r, cause_nxt;
  seq_state_t state_r, state_nxt;
  logic [6:0] wait_cnt_r, wait_cnt_nxt;
  logic [7:0] lvsel_r, lvsel_nxt;
  logic [7:0] lvctl_r, lvctl_nxt;
  logic [4:0] irq_sts_r, irq_sts_nxt;
  logic [4:0] irq_msk_r;
  logic [31:0] rdata_nxt;
  logic       ack_r;

  // Pin and power-on clear come from outside the clock domain
  rise_sync u_pin_sync (
    .pclk       (pclk),
    .presetn    (presetn),
    .async_in   (~rst_pin_n),
    .rise_pulse (src.pin)
  );

  rise_sync u_poc_sync (
    .pclk       (pclk),
    .presetn    (presetn),
    .async_in   (poc_active),
    .rise_pulse (src.power_on_clear)
  );

  assign src.bad = op_exec & (op_code == BAD_OPCODE);
  assign src.wdg = wdg_expire;
  assign src.lvd = lvd_trip;

  wire any_src   = |src;
  wire full_rst  = src.pin | src.power_on_clear | src.bad | src.wdg;

  // APB decode; zero wait states
  wire setup_ph  = psel & ~penable;
  wire access_ph = psel & penable;
  wire hit_cause = (paddr == OFS_CAUSE);
  wire hit_lvsel = (paddr == OFS_LVSEL);
  wire hit_lvctl = (paddr == OFS_LVCTL);
  wire hit_sts   = (paddr == OFS_IRQ_STS);
  wire hit_msk   = (paddr == OFS_IRQ_MSK);
  wire mapped    = hit_cause | hit_lvsel | hit_lvctl | hit_sts | hit_msk;
  wire wr_acc    = access_ph & pwrite & mapped;
  wire rd_cause  = access_ph & ~pwrite & hit_cause;

  assign pready  = 1'b1;
  assign pslverr = access_ph & ~mapped;

  wire cause_clr = src.pin | src.power_on_clear | rd_cause;

  // flags set by their source, held otherwise; set beats clear
  assign cause_nxt.bad = src.bad | (cause_r.bad & ~cause_clr);
  assign cause_nxt.wdg = src.wdg | (cause_r.wdg & ~cause_clr);
  assign cause_nxt.brn = src.lvd | (cause_r.brn & ~cause_clr);

  assign lvsel_nxt = full_rst ? LVSEL_RST :
                     (wr_acc & hit_lvsel) ? pwdata[7:0] : lvsel_r;

  // control default from source and option byte
  wire [7:0] lvctl_opt = opt_lvd_default_on ?
                         (LVCTL_RST | (8'h01 << LVCTL_EN_BIT) | (8'h01 << LVCTL_MODE_BIT)) :
                         LVCTL_RST;
  // A low-voltage reset keeps the detector running so it can release the reset
  wire [7:0] lvctl_lvd = LVCTL_RST | (lvctl_r & (8'h01 << LVCTL_EN_BIT))
                         | (8'h01 << LVCTL_MODE_BIT);
  assign lvctl_nxt = full_rst ? lvctl_opt :
                     src.lvd  ? lvctl_lvd :
                     (wr_acc & hit_lvctl) ? pwdata[7:0] : lvctl_r;

  // Sticky status, write one to clear, new events win
  assign irq_sts_nxt = src | (irq_sts_r & ~((wr_acc & hit_sts) ? pwdata[4:0] : 5'h00));
  assign irq = |(irq_sts_r & irq_msk_r);

  // Read data, captured in the setup phase
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (hit_cause) begin
      rdata_nxt[CAUSE_BAD_BIT] = cause_r.bad;
      rdata_nxt[CAUSE_WDG_BIT] = cause_r.wdg;
      rdata_nxt[CAUSE_BRN_BIT] = cause_r.brn;
    end else if (hit_lvsel) begin
      rdata_nxt[7:0] = lvsel_r;
    end else if (hit_lvctl) begin
      rdata_nxt[7:0] = lvctl_r;
    end else if (hit_sts) begin
      rdata_nxt[4:0] = irq_sts_r;
    end else if (hit_msk) begin
      rdata_nxt[4:0] = irq_msk_r;
    end
  end

  // wait sequence; a new source restarts the wait
  always_comb begin
    state_nxt    = state_r;
    wait_cnt_nxt = wait_cnt_r;
    unique case (state_r)
      ST_RUN: begin
        if (any_src) begin
          state_nxt    = ST_WAIT;
          wait_cnt_nxt = OSC_WAIT_CYC;
        end
      end
      ST_WAIT: begin
        if (any_src) begin
          wait_cnt_nxt = OSC_WAIT_CYC;
        end else if (wait_cnt_r == 7'd1) begin
          state_nxt    = ST_RUN;
          wait_cnt_nxt = 7'd0;
        end else begin
          wait_cnt_nxt = wait_cnt_r - 7'd1;
        end
      end
      default: begin
        state_nxt    = ST_RUN;
        wait_cnt_nxt = 7'd0;
      end
    endcase
  end

  // Cause and detector registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_r <= '0;
      lvsel_r <= LVSEL_RST;
      lvctl_r <= LVCTL_RST;
    end else begin
      cause_r <= cause_nxt;
      lvsel_r <= lvsel_nxt;
      lvctl_r <= lvctl_nxt;
    end
  end

  // Interrupt registers and read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts_r <= 5'h00;
      irq_msk_r <= IRQ_MSK_RST;
      prdata    <= 32'h0000_0000;
    end else begin
      irq_sts_r <= irq_sts_nxt;
      if (wr_acc & hit_msk) irq_msk_r <= pwdata[4:0];
      if (setup_ph) prdata <= rdata_nxt;
    end
  end

  // Sequencer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= ST_RUN;
      wait_cnt_r <= 7'd0;
      ack_r      <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      wait_cnt_r <= wait_cnt_nxt;
      ack_r      <= (state_r == ST_WAIT) & (state_nxt == ST_RUN);
    end
  end

  // program counter flagged undefined only while waiting
  assign sys_reset_req = (state_r == ST_WAIT);
  assign pc_undefined  = (state_r == ST_WAIT);
  assign reset_ack     = ack_r;

  // opcode FF sets the bad-opcode flag
  chk_bad_opcode: assert property (@(posedge pclk) disable iff (!presetn)
    (op_exec && op_code == BAD_OPCODE) |=> cause_r.bad && pc_undefined)
    else $error("illegal opcode did not trap");

  // watchdog source holds the bad-opcode flag
  chk_flag_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (src.wdg && !src.bad && !cause_clr) |=> (cause_r.bad == $past(cause_r.bad)) && cause_r.wdg)
    else $error("cause flag not held on watchdog reset");

  chk_lvsel_reload: assert property (@(posedge pclk) disable iff (!presetn)
    full_rst |=> lvsel_r == LVSEL_RST)
    else $error("level select not reloaded");

  chk_lvsel_held: assert property (@(posedge pclk) disable iff (!presetn)
    (src.lvd && !full_rst && !wr_acc) |=> $stable(lvsel_r))
    else $error("level select changed on low-voltage reset");

  // control value after a full reset
  chk_lvctl_value: assert property (@(posedge pclk) disable iff (!presetn)
    (full_rst && !opt_lvd_default_on) |=> lvctl_r == LVCTL_RST)
    else $error("detect control not defaulted");

  // Cycles since the latest source, saturating; kept apart from the wait counter
  logic [6:0] since_src_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_src_r <= 7'h00;
    end else if (any_src) begin
      since_src_r <= 7'h01;
    end else if (since_src_r != 7'h00 && since_src_r != 7'h7F) begin
      since_src_r <= since_src_r + 7'h01;
    end
  end

  // wait lasts the full stabilization count
  chk_pc_wait: assert property (@(posedge pclk) disable iff (!presetn)
    pc_undefined == ((since_src_r != 7'h00) && (since_src_r <= OSC_WAIT_CYC)))
    else $error("stabilization wait length wrong");

  // read clears flags unless a source sets them
  chk_cause_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_cause && !src.bad && !src.wdg && !src.lvd) |=> cause_r == 3'b000)
    else $error("cause flags not cleared");

  chk_multi_set: assert property (@(posedge pclk) disable iff (!presetn)
    (src.wdg && src.lvd) |=> cause_r.wdg && cause_r.brn)
    else $error("simultaneous causes not all set");

endmodule : reset_cause_recorder

//--- dv/tb.sv
`timescale 1ns/100ps
module tb;
  import rcr_pkg::*;
  // One ordinary case: sources fired, opt level, expected results
  typedef struct packed {
    logic       wdg;
    logic       lvd;
    logic       opx;
    logic [7:0] code;
    logic       opt;
    logic [7:0] cause;
    logic [4:0] sts;
    logic [7:0] lvsel;
    logic [7:0] lvctl;
  } row_t;
  // Bench signals
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, op_code = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic        pready, pslverr, err, sys_reset_req, pc_undefined, reset_ack, irq;
  logic        rst_pin_n = 1'b1, poc_active = 1'b0, wdg_expire = 1'b0, lvd_trip = 1'b0;
  logic        op_exec = 1'b0, opt_lvd_default_on = 1'b0;
  int          mismatches = 0, cmp_count = 0;
  row_t        rows [6];

  reset_cause_recorder i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .rst_pin_n(rst_pin_n), .poc_active(poc_active),
    .wdg_expire(wdg_expire), .lvd_trip(lvd_trip), .op_exec(op_exec), .op_code(op_code),
    .opt_lvd_default_on(opt_lvd_default_on), .sys_reset_req(sys_reset_req),
    .pc_undefined(pc_undefined), .reset_ack(reset_ack), .irq(irq));

  // 25 MHz clock
  always #20 pclk = ~pclk;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // APB cycle; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends a wait that never sees pready
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdata = prdata;
    err   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Let the access edge settle so later checks see the new register values
    #1;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rdata);
  endtask : rd

  // Counts wait cycles and acks; sampling starts right after the event edge
  task automatic settle(input logic ev);
    int pcn, ack, srq;
    pcn = 0;
    ack = 0;
    srq = 0;
    repeat (70) begin
      #1;
      pcn += int'(pc_undefined === 1'b1);
      ack += int'(reset_ack === 1'b1);
      srq += int'(sys_reset_req === 1'b1);
      @(posedge pclk);
    end
    chk("pc_undefined cycles", ev ? 32'(OSC_WAIT_CYC) : 32'h0, 32'(pcn));
    chk("sys_reset_req cycles", ev ? 32'(OSC_WAIT_CYC) : 32'h0, 32'(srq));
    chk("reset_ack pulses", 32'(ev), 32'(ack));
  endtask : settle

  task automatic fire(input row_t r);
    @(posedge pclk);
    wdg_expire         <= r.wdg;
    lvd_trip           <= r.lvd;
    op_exec            <= r.opx;
    op_code            <= r.code;
    opt_lvd_default_on <= r.opt;
    @(posedge pclk);
    wdg_expire <= 1'b0;
    lvd_trip   <= 1'b0;
    op_exec    <= 1'b0;
    settle(r.sts != 5'h00);
  endtask : fire

  // Pin reset when pin is set, otherwise power-on clear
  task automatic ext(input logic pin);
    @(posedge pclk);
    rst_pin_n  <= ~pin;
    poc_active <= ~pin;
    @(posedge pclk);
    rst_pin_n  <= 1'b1;
    poc_active <= 1'b0;
    settle(1'b1);
  endtask : ext

  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  // Watchdog, far beyond the roughly 1100 cycles the sequence needs
  initial begin
    #(40 * 20000);
    mismatches++;
    final_report();
  end

  initial begin
    rows = '{'{1'h1, 1'h0, 1'h0, 8'h00, 1'h0, 8'h02, 5'h08, 8'h0E, 8'h00},
             '{1'h0, 1'h1, 1'h0, 8'h00, 1'h0, 8'h01, 5'h10, 8'h05, 8'h82},
             '{1'h0, 1'h0, 1'h1, 8'hFF, 1'h1, 8'h10, 5'h04, 8'h0E, 8'h82},
             '{1'h0, 1'h0, 1'h1, 8'hFE, 1'h1, 8'h00, 5'h00, 8'h05, 8'h80},
             '{1'h1, 1'h0, 1'h1, 8'hFF, 1'h0, 8'h12, 5'h0C, 8'h0E, 8'h00},
             '{1'h1, 1'h1, 1'h0, 8'h00, 1'h0, 8'h03, 5'h18, 8'h0E, 8'h00}};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // Register reset values
    rd(OFS_LVSEL, 32'h0E);
    rd(OFS_LVCTL, 32'h00);
    rd(OFS_CAUSE, 32'h00);
    rd(OFS_IRQ_MSK, 32'h00);
    apb(1'b1, OFS_IRQ_MSK, 32'h1F);
    // Ordinary cases: watchdog, low voltage and bad opcode alone, a near-miss opcode and two at once
    foreach (rows[i]) begin
      apb(1'b1, OFS_LVSEL, 32'h05);
      apb(1'b1, OFS_LVCTL, 32'h80);
      fire(rows[i]);
      chk("irq", 32'(rows[i].sts != 5'h00), 32'(irq));
      rd(OFS_CAUSE, 32'(rows[i].cause));
      rd(OFS_CAUSE, 32'h00);
      rd(OFS_IRQ_STS, 32'(rows[i].sts));
      rd(OFS_LVSEL, 32'(rows[i].lvsel));
      rd(OFS_LVCTL, 32'(rows[i].lvctl));
      apb(1'b1, OFS_IRQ_STS, 32'h1F);
      rd(OFS_IRQ_STS, 32'h00);
    end
    // Watchdog flag held over a later trap; masking gates the interrupt
    fire(rows[0]);
    fire(rows[2]);
    rd(OFS_CAUSE, 32'h12);
    apb(1'b1, OFS_IRQ_MSK, 32'h00);
    chk("irq masked", 32'h0, 32'(irq));
    apb(1'b1, OFS_IRQ_MSK, 32'h08);
    chk("irq unmasked", 32'h1, 32'(irq));
    apb(1'b1, OFS_IRQ_STS, 32'h08);
    chk("irq cleared", 32'h0, 32'(irq));
    // Pin and power-on clear wipe the flags; the level select reload is checked after the pin reset only
    apb(1'b1, OFS_IRQ_STS, 32'h1F);
    fire(rows[0]);
    apb(1'b1, OFS_LVSEL, 32'h05);
    ext(1'b1);
    rd(OFS_CAUSE, 32'h00);
    rd(OFS_LVSEL, 32'h0E);
    rd(OFS_IRQ_STS, 32'h09);
    fire(rows[1]);
    ext(1'b0);
    rd(OFS_CAUSE, 32'h00);
    rd(OFS_IRQ_STS, 32'h1B);
    // Unmapped word: refused, reads zero
    rd(8'h14, 32'h00);
    chk("pslverr", 32'h1, 32'(err));
    final_report();
  end
endmodule : tb
